/* rtl/fesr_status.sv */
`timescale 1ns/1ps
// What this block does
// - Failed program/erase/blank/unlock keeps engine active, ready shown, until cleared
// - Operation error: bit5 erase/blank, bit4 program/password, bits 2,1 zero
// - Reset or status clear leaves error; only read, reset, clear accepted
// - Guarded program/erase: busy 20-100 us, bit7 low, only status read
// - After protection busy: ready, bit1 set, bit5 erase or bit4 program
// - New program clears bit4; new erase clears bit6 at once
// - Buffer write failure: abort state, ready, bits 3,4 set, 5,2,1 clear
// - Abort cleared by abort reset or status clear; status read keeps abort
// - Non-status reads during embedded work toggle strobe, data indeterminate
// - Interrupt pulses for each one- or two-bit ECC error when enabled
// - Stall mode: strobe stops on two-bit error; host times out 32 clocks
// - ECC status word is 16-bit read-only, read via command plus unit
// - Double and single flags are global, independent of unit address
// - Unit bits: 0 disabled, 1 data corrected, 2 code error
// - Single-bit flag sets on correction, holds until overlay exit clears
// - Double-bit flag sets on detection, holds; failing address trapped
// - After a two-bit event bits 3..1 are not valid to the host
// - The ECC read's own check may set the global flags it returns
// - ECC status bits 4,3 zero on hardware reset, or on overlay exit with no event that cycle; bits 2..0 are the addressed unit's
// - Guarded targets raise protection error and abort the operation
// - After clearing error, prior overlay or erase suspend is kept
// - Overlay exit clears trapped address and both global flags, except where an event lands in the same cycle
module fesr_status
(
    input  wire logic                      clk,
    input  wire logic                      rstn,
    input  wire fesr_pkg::fesr_cmd_s       cmd,
    input  wire fesr_pkg::fesr_eng_s       eng,
    input  wire logic                      ecc_valid,
    input  wire fesr_pkg::fesr_ecc_s       ecc,
    input  wire logic                      int_enable,
    input  wire logic                      stall_enable,
    input  wire logic                      bus_clk,
    input  wire logic                      bus_cs_n,
    input  wire logic                      read_data_strobe_i,
    output logic                           read_data_strobe_o,
    output logic                           read_data_strobe_oe,
    output logic                           op_start,
    output logic [7:0]                     operation_status_word,
    output logic [15:0]                    rd_data,
    output logic                           rd_valid,
    output logic                           rd_indeterminate,
    output logic                           ecc_overlay,
    output logic [fesr_pkg::ADDR_W-1:0]    trap_addr,
    output logic                           int_n
);
    import fesr_pkg::*;

    typedef enum logic [2:0] {
        ST_READY, ST_BUSY, ST_PROT_BUSY, ST_OP_ERROR, ST_WB_ABORT
    } fesr_state_e;

    fesr_state_e state;
    fesr_kind_e  kind;
    logic [11:0] prot_cnt;
    logic        single_flag;
    logic        double_flag;
    logic        trap_full;
    logic        ck_s1, ck_s2, ck_s3;
    logic        cs_s1, cs_s2;
    logic        stalled;

    function automatic logic is_op(input fesr_cmd_e c);
        return c == CMD_PROGRAM || c == CMD_ERASE || c == CMD_BLANK_CHECK
            || c == CMD_PW_UNLOCK || c == CMD_WRITE_BUFFER;
    endfunction

    function automatic fesr_kind_e kind_of(input fesr_cmd_e c);
        case (c)
            CMD_ERASE:        return KIND_ERASE;
            CMD_BLANK_CHECK:  return KIND_BLANK;
            CMD_PW_UNLOCK:    return KIND_UNLOCK;
            CMD_WRITE_BUFFER: return KIND_BUF;
            default:          return KIND_PROG;
        endcase
    endfunction

    wire cmd_ok    = cmd.valid && state == ST_READY;
    wire start_op  = cmd_ok && is_op(cmd.code) && !cmd.guarded;
    wire guard_hit = cmd_ok && is_op(cmd.code) && cmd.guarded;
    wire err_clear = cmd.valid && (
        (state == ST_OP_ERROR && (cmd.code == CMD_RESET
            || cmd.code == CMD_STATUS_CLEAR))
        || (state == ST_WB_ABORT && (cmd.code == CMD_BUF_ABORT_RESET
            || cmd.code == CMD_STATUS_CLEAR)));
    wire prot_end  = state == ST_PROT_BUSY && prot_cnt == 12'h001;
    wire aso_exit  = cmd_ok && ecc_overlay
        && (cmd.code == CMD_RESET || cmd.code == CMD_ASO_EXIT);
    wire single_ev = ecc_valid && ecc.single_bit;
    wire double_ev = ecc_valid && ecc.double_bit;

    // Engine state; error states only leave on their own clear commands
    always_ff @(posedge clk) begin
        if (!rstn) begin
            state <= ST_READY;
            kind  <= KIND_PROG;
        end else begin
            case (state)
                ST_READY: begin
                    if (guard_hit) begin
                        state <= ST_PROT_BUSY;
                        kind  <= kind_of(cmd.code);
                    end else if (start_op) begin
                        state <= ST_BUSY;
                        kind  <= kind_of(cmd.code);
                    end
                end
                ST_BUSY: begin
                    if (eng.buf_fail && kind == KIND_BUF) begin
                        state <= ST_WB_ABORT;
                    end else if (eng.fail) begin
                        state <= ST_OP_ERROR;
                    end else if (eng.done) begin
                        state <= ST_READY;
                    end
                end
                ST_PROT_BUSY: begin
                    if (prot_end) begin
                        state <= ST_READY;
                    end
                end
                default: begin
                    // Other commands fall through untouched
                    if (err_clear) begin
                        state <= ST_READY;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            prot_cnt <= 12'h000;
        end else if (guard_hit) begin
            prot_cnt <= 12'(PROT_BUSY_CYC);
        end else if (prot_cnt != 12'h000) begin
            prot_cnt <= prot_cnt - 12'h001;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            op_start <= 1'b0;
        end else begin
            op_start <= start_op;
        end
    end

    // Status word; suspend and overlay context survive an error clear
    always_ff @(posedge clk) begin
        if (!rstn) begin
            operation_status_word <= SR_RESET;
        end else begin
            operation_status_word[SR_READY] <=
                !(start_op || guard_hit)
                && (state != ST_BUSY || eng.done || eng.fail
                    || (eng.buf_fail && kind == KIND_BUF))
                && (state != ST_PROT_BUSY || prot_end);
            operation_status_word[SR_PROG_SUSP] <= 1'b0;
            if (cmd_ok && cmd.code == CMD_ERASE_SUSPEND) begin
                operation_status_word[SR_ERASE_SUSP] <= 1'b1;
            end else if (start_op && cmd.code == CMD_ERASE) begin
                operation_status_word[SR_ERASE_SUSP] <= 1'b0;
            end
            if (start_op && cmd.code == CMD_PROGRAM) begin
                operation_status_word[SR_PROG_ERR] <= 1'b0;
            end
            if (state == ST_BUSY && eng.buf_fail && kind == KIND_BUF) begin
                operation_status_word[SR_BUF_ABORT] <= 1'b1;
                operation_status_word[SR_PROG_ERR]  <= 1'b1;
                operation_status_word[SR_ERASE_ERR] <= 1'b0;
                operation_status_word[SR_PROTECT]   <= 1'b0;
            end else if (state == ST_BUSY && eng.fail) begin
                operation_status_word[SR_ERASE_ERR] <=
                    kind == KIND_ERASE || kind == KIND_BLANK;
                operation_status_word[SR_PROG_ERR] <=
                    kind == KIND_PROG || kind == KIND_UNLOCK
                    || kind == KIND_BUF;
                operation_status_word[SR_PROTECT] <= 1'b0;
            end else if (prot_end) begin
                operation_status_word[SR_PROTECT]   <= 1'b1;
                operation_status_word[SR_ERASE_ERR] <= kind == KIND_ERASE;
                operation_status_word[SR_PROG_ERR]  <= kind != KIND_ERASE;
            end else if (err_clear || (cmd_ok
                    && cmd.code == CMD_STATUS_CLEAR)) begin
                operation_status_word[SR_ERASE_ERR] <= 1'b0;
                operation_status_word[SR_PROG_ERR]  <= 1'b0;
                operation_status_word[SR_BUF_ABORT] <= 1'b0;
                operation_status_word[SR_PROTECT]   <= 1'b0;
            end
        end
    end

    // ECC overlay entry and exit
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ecc_overlay <= 1'b0;
        end else if (cmd_ok && cmd.code == CMD_ECC_ENTRY) begin
            ecc_overlay <= 1'b1;
        end else if (aso_exit) begin
            ecc_overlay <= 1'b0;
        end
    end

    // Global flags: a new event beats a same-cycle exit
    always_ff @(posedge clk) begin
        if (!rstn) begin
            single_flag <= 1'b0;
            double_flag <= 1'b0;
        end else begin
            single_flag <= single_ev || (single_flag && !aso_exit);
            double_flag <= double_ev || (double_flag && !aso_exit);
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            trap_addr <= TRAP_RESET;
            trap_full <= 1'b0;
        end else if (double_ev && (!trap_full || aso_exit)) begin
            trap_addr <= ecc.addr;
            trap_full <= 1'b1;
        end else if (aso_exit) begin
            trap_addr <= TRAP_RESET;
            trap_full <= 1'b0;
        end
    end

    // Read data path; status read is honoured in every state
    always_ff @(posedge clk) begin
        if (!rstn) begin
            rd_data          <= 16'h0000;
            rd_valid         <= 1'b0;
            rd_indeterminate <= 1'b0;
        end else begin
            rd_valid         <= 1'b0;
            rd_indeterminate <= 1'b0;
            if (cmd.valid && cmd.code == CMD_STATUS_READ) begin
                rd_valid <= 1'b1;
                rd_data  <= {8'h00, operation_status_word};
            end else if (cmd.valid && state == ST_BUSY
                    && (cmd.code == CMD_ARRAY_READ
                    || cmd.code == CMD_ECC_READ)) begin
                rd_valid         <= 1'b1;
                rd_indeterminate <= 1'b1;
                rd_data          <= 16'h0000;
            end else if (cmd_ok && ecc_overlay
                    && cmd.code == CMD_ECC_READ) begin
                rd_valid <= 1'b1;
                // Reserved bits driven zero; this read's own check counts
                rd_data  <= {11'h000, double_flag || double_ev,
                    single_flag || single_ev, cmd.unit_bits};
            end else if (cmd_ok && cmd.code == CMD_ARRAY_READ) begin
                rd_valid <= 1'b1;
                rd_data  <= cmd.array_data;
            end
        end
    end

    // Interrupt: one low cycle per detected error
    always_ff @(posedge clk) begin
        if (!rstn) begin
            int_n <= 1'b1;
        end else begin
            int_n <= !(int_enable && (single_ev || double_ev));
        end
    end

    // Bus pins are asynchronous to clk; logic reads only the second and third stages
    always_ff @(posedge clk) begin
        if (!rstn) begin
            ck_s1 <= 1'b0;
            ck_s2 <= 1'b0;
            ck_s3 <= 1'b0;
            cs_s1 <= 1'b1;
            cs_s2 <= 1'b1;
        end else begin
            ck_s1 <= bus_clk;
            ck_s2 <= ck_s1;
            ck_s3 <= ck_s2;
            cs_s1 <= bus_cs_n;
            cs_s2 <= cs_s1;
        end
    end

    wire ck_edge = ck_s2 != ck_s3;

    // Stall held until chip select rises; host times out after 32 clocks
    always_ff @(posedge clk) begin
        if (!rstn) begin
            stalled <= 1'b0;
        end else if (cs_s2) begin
            stalled <= 1'b0;
        end else if (stall_enable && double_ev) begin
            stalled <= 1'b1;
        end
    end

    always_ff @(posedge clk) begin
        if (!rstn) begin
            read_data_strobe_o  <= 1'b0;
            read_data_strobe_oe <= 1'b0;
        end else begin
            read_data_strobe_oe <= !cs_s2;
            if (cs_s2 || stalled || (stall_enable && double_ev)) begin
                read_data_strobe_o <= 1'b0;
            end else if (ck_edge) begin
                read_data_strobe_o <= !read_data_strobe_o;
            end
        end
    end

    prot_bit_low_a: assert property (@(posedge clk) disable iff (!rstn)
        state == ST_PROT_BUSY |-> !operation_status_word[SR_READY])
        else $error("ready shown during protection busy");
    prot_len_a: assert property (@(posedge clk) disable iff (!rstn)
        guard_hit |=> state == ST_PROT_BUSY [*8])
        else $error("protection busy too short");
    prot_flag_a: assert property (@(posedge clk) disable iff (!rstn)
        prot_end |=> operation_status_word[SR_PROTECT]
        && operation_status_word[SR_READY])
        else $error("protection flag missing");
    op_err_hold_a: assert property (@(posedge clk)
        disable iff (!rstn)
        state == ST_OP_ERROR && !err_clear |=> state == ST_OP_ERROR)
        else $error("operation error left without clear");
    op_err_bits_a: assert property (@(posedge clk) disable iff (!rstn)
        state == ST_OP_ERROR |-> operation_status_word[SR_READY]
        && !operation_status_word[SR_PROG_SUSP]
        && !operation_status_word[SR_PROTECT])
        else $error("operation error bits wrong");
    abort_bits_a: assert property (@(posedge clk) disable iff (!rstn)
        state == ST_BUSY && eng.buf_fail && kind == KIND_BUF |=>
        operation_status_word[SR_BUF_ABORT]
        && operation_status_word[SR_PROG_ERR]
        && !operation_status_word[SR_ERASE_ERR])
        else $error("abort bits wrong");
    abort_read_a: assert property (@(posedge clk) disable iff (!rstn)
        state == ST_WB_ABORT && cmd.valid && cmd.code == CMD_STATUS_READ
        |=> state == ST_WB_ABORT && rd_valid)
        else $error("status read left abort state");
    exit_clear_a: assert property (@(posedge clk) disable iff (!rstn)
        aso_exit && !ecc_valid |=> !single_flag && !double_flag
        && trap_addr == TRAP_RESET)
        else $error("overlay exit left ecc state");
    dbl_hold_a: assert property (@(posedge clk) disable iff (!rstn)
        double_ev ##1 !aso_exit [*3] |=> double_flag)
        else $error("double flag dropped");
    int_pulse_a: assert property (@(posedge clk) disable iff (!rstn)
        int_enable && single_ev |=> !int_n)
        else $error("interrupt missed");
    strobe_stall_a: assert property (@(posedge clk) disable iff (!rstn)
        stalled && !cs_s2 |=> !read_data_strobe_o)
        else $error("strobe toggled while stalled");
endmodule // fesr_status

/* common/fesr_pkg.sv */
package fesr_pkg;
    // Operation status word bit positions
    localparam int SR_READY      = 7;
    localparam int SR_ERASE_SUSP = 6;
    localparam int SR_ERASE_ERR  = 5;
    localparam int SR_PROG_ERR   = 4;
    localparam int SR_BUF_ABORT  = 3;
    localparam int SR_PROG_SUSP  = 2;
    localparam int SR_PROTECT    = 1;
    localparam logic [7:0] SR_RESET = 8'h80;

    // ECC unit status word bit positions
    localparam int ECC_UNIT_DIS  = 0;
    localparam int ECC_DATA_COR  = 1;
    localparam int ECC_CODE_ERR  = 2;
    localparam int ECC_SINGLE    = 3;
    localparam int ECC_DOUBLE    = 4;
    localparam logic [15:0] ECC_RESET = 16'h0000;
    localparam int ADDR_W = 25;
    localparam logic [ADDR_W-1:0] TRAP_RESET = 25'h0000000;

    // Protection busy window, least time used
    localparam int CLK_NS       = 50;
    localparam int PROT_BUSY_US = 20;
    localparam int PROT_BUSY_CYC = (PROT_BUSY_US * 1000 + CLK_NS - 1) / CLK_NS;

    typedef enum logic [3:0] {
        CMD_STATUS_READ, CMD_STATUS_CLEAR, CMD_RESET, CMD_BUF_ABORT_RESET,
        CMD_PROGRAM, CMD_ERASE, CMD_BLANK_CHECK, CMD_PW_UNLOCK,
        CMD_WRITE_BUFFER, CMD_ECC_ENTRY, CMD_ECC_READ, CMD_ASO_EXIT,
        CMD_ARRAY_READ, CMD_ERASE_SUSPEND, CMD_OTHER
    } fesr_cmd_e;

    typedef enum logic [2:0] {
        KIND_PROG, KIND_ERASE, KIND_BLANK, KIND_UNLOCK, KIND_BUF
    } fesr_kind_e;

    typedef struct packed {
        logic             valid;
        fesr_cmd_e        code;
        logic             guarded;   // Volatile/persistent guard or lock
        logic [2:0]       unit_bits; // Per-unit ECC bits of addressed unit
        logic [15:0]      array_data;
    } fesr_cmd_s;

    typedef struct packed {
        logic done;
        logic fail;
        logic buf_fail;
    } fesr_eng_s;

    typedef struct packed {
        logic              single_bit;
        logic              double_bit;
        logic [ADDR_W-1:0] addr;
    } fesr_ecc_s;
endpackage

/* verification/fesr_host_model.sv */
`timescale 1ns/1ps
module fesr_host_model #(
    parameter int FRAME_CLKS  = 48,
    parameter int STALL_LIMIT = 32
) (
    input  wire logic rds,
    input  wire logic frame_go,
    output logic      bus_clk,
    output logic      bus_cs_n,
    output logic      frame_done,
    output logic      bus_error,
    output int        toggles
);
    logic moved;
    int   quiet;

    // Bus clock stands still between frames
    initial begin
        bus_clk = 1'b0;
        bus_cs_n = 1'b1;
        frame_done = 1'b0;
        bus_error = 1'b0;
        toggles = 0;
        moved = 1'b0;
        quiet = 0;
        forever begin
            wait (frame_go === 1'b1);
            #137;
            bus_error = 1'b0;
            toggles = 0;
            quiet = 0;
            bus_cs_n = 1'b0;
            #400;
            repeat (FRAME_CLKS) begin
                #200 bus_clk = 1'b1;
                quiet = moved ? 0 : quiet + 1;
                moved = 1'b0;
                // Silent strobe beyond the limit is a bus error
                if (quiet > STALL_LIMIT) bus_error = 1'b1;
                #200 bus_clk = 1'b0;
            end
            #400 bus_cs_n = 1'b1;
            frame_done = 1'b1;
            wait (frame_go === 1'b0);
            frame_done = 1'b0;
        end
    end

    always @(rds) begin
        if (!bus_cs_n) begin
            moved = 1'b1;
            toggles++;
        end
    end
endmodule // fesr_host_model

/* verification/flash_error_status_reporting_test.sv */
`timescale 1ns/1ps
module flash_error_status_reporting_test;
    import fesr_pkg::*;
    typedef struct packed {
        logic [15:0] data;
        logic [15:0] mask;
        logic        ind;
    } fesr_exp_s;

    logic              clk = 1'b0;
    logic              rstn = 1'b0;
    fesr_cmd_s         cmd = '0;
    fesr_eng_s         eng = '0;
    logic              ecc_valid = 1'b0;
    fesr_ecc_s         ecc = '0;
    logic              int_enable = 1'b0;
    logic              stall_enable = 1'b0;
    logic              frame_go = 1'b0;
    logic              rds_last = 1'b0;
    logic              bus_clk, bus_cs_n, rds_i, rds_o, rds_oe, op_start;
    logic              rd_valid, rd_ind, ecc_overlay, int_n, frame_done;
    logic              bus_error;
    logic [7:0]        sw;
    logic [15:0]       rd_data;
    logic [ADDR_W-1:0] trap_addr, a;
    logic [2:0]        u;
    int                toggles, errors = 0, checks_done = 0, cyc = 0, t0;
    integer            seed = 32'hA85FB118;
    fesr_exp_s         expq[$];
    fesr_cmd_e kinds[4] = '{CMD_PROGRAM, CMD_ERASE, CMD_BLANK_CHECK,
                            CMD_PW_UNLOCK};
    logic [7:0] errs[4] = '{8'h90, 8'hA0, 8'hA0, 8'h90};

    always #25 clk = ~clk;
    always @(posedge clk) cyc <= cyc + 1;
    // Floating strobe shows the inverse of its last driven level
    always @(posedge clk) if (rds_oe) rds_last <= rds_o;
    assign rds_i = rds_oe ? rds_o : ~rds_last;

    fesr_status uut (.clk(clk), .rstn(rstn), .cmd(cmd), .eng(eng),
        .ecc_valid(ecc_valid), .ecc(ecc), .int_enable(int_enable),
        .stall_enable(stall_enable), .bus_clk(bus_clk),
        .bus_cs_n(bus_cs_n), .read_data_strobe_i(rds_i),
        .read_data_strobe_o(rds_o), .read_data_strobe_oe(rds_oe),
        .op_start(op_start), .operation_status_word(sw),
        .rd_data(rd_data), .rd_valid(rd_valid), .rd_indeterminate(rd_ind),
        .ecc_overlay(ecc_overlay), .trap_addr(trap_addr), .int_n(int_n));

    fesr_host_model host (.rds(rds_i), .frame_go(frame_go),
        .bus_clk(bus_clk), .bus_cs_n(bus_cs_n), .frame_done(frame_done),
        .bus_error(bus_error), .toggles(toggles));

    task automatic check(string name, logic [31:0] seen, logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic summarize();
        if (errors == 0 && checks_done > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask

    task automatic step(logic cv, fesr_cmd_e c, logic g = 1'b0,
                        logic [2:0] uu = 3'h0, logic [1:0] ev = 2'b00,
                        logic [ADDR_W-1:0] aa = '0);
        @(negedge clk);
        cmd = '{cv, c, g, uu, 16'($random(seed))};
        ecc_valid = |ev;
        ecc = '{ev[0], ev[1], aa};
        @(negedge clk);
        cmd.valid = 1'b0;
        ecc_valid = 1'b0;
    endtask

    task automatic eng_pulse(fesr_eng_s e);
        @(negedge clk);
        eng = e;
        @(negedge clk);
        eng = '0;
    endtask

    // Expectation noted before the request, matched by the monitor
    task automatic rd(fesr_cmd_e c, logic [15:0] d, logic [15:0] m,
                      logic ind, logic [2:0] uu = 3'h0,
                      logic [1:0] ev = 2'b00);
        expq.push_back('{d, m, ind});
        step(1'b1, c, 1'b0, uu, ev);
    endtask

    task automatic st(logic [7:0] e, logic [7:0] m);
        check("status", sw & m, e & m);
    endtask

    always @(negedge clk) begin
        fesr_exp_s e;
        if (rstn && rd_valid === 1'b1) begin
            if (expq.size() == 0) begin
                check("unexpected read", 1'b1, 1'b0);
            end else begin
                e = expq.pop_front();
                check("read kind", rd_ind, e.ind);
                check("read data", rd_data & e.mask, e.data & e.mask);
            end
        end
    end

    initial begin
        #1000000;
        errors++;
        summarize();
    end

    initial begin
        repeat (20) @(negedge clk);
        rstn = 1'b1;
        st(8'h80, 8'hFF);
        step(1'b1, CMD_ERASE_SUSPEND);
        check("suspend bit", sw[SR_ERASE_SUSP], 1'b1);
        for (int i = 0; i < 4; i++) begin
            step(1'b1, kinds[i]);
            check("op start", op_start, 1'b1);
            if (i == 1) check("suspend bit", sw[SR_ERASE_SUSP], 1'b0);
            rd(CMD_ARRAY_READ, 16'h0, 16'h0, 1'b1);
            rd(CMD_STATUS_READ, 16'h0, 16'h0080, 1'b0);
            eng_pulse('{1'b0, 1'b1, 1'b0});
            st(errs[i], 8'hB6);
            step(1'b1, CMD_ERASE);
            check("op start", op_start, 1'b0);
            step(1'b1, CMD_ARRAY_READ);
            rd(CMD_STATUS_READ, {8'h0, errs[i]}, 16'h00B6, 1'b0);
            step(1'b1, i[0] ? CMD_RESET : CMD_STATUS_CLEAR);
            st(8'h80, 8'hB6);
            if (i == 0) check("suspend kept", sw[SR_ERASE_SUSP], 1'b1);
        end
        for (int i = 0; i < 2; i++) begin
            step(1'b1, i ? CMD_ERASE : CMD_PROGRAM, 1'b1);
            t0 = cyc;
            check("op start", op_start, 1'b0);
            rd(CMD_STATUS_READ, 16'h0, 16'h0080, 1'b0);
            step(1'b1, CMD_RESET);
            for (int k = 0; k < 3000 && sw[SR_READY] !== 1'b1; k++)
                @(negedge clk);
            check("busy span", (cyc - t0 >= 400) && (cyc - t0 <= 2000), 1);
            st(i ? 8'hA2 : 8'h92, 8'hB6);
            step(1'b1, i ? CMD_ERASE : CMD_PROGRAM);
            check("op start", op_start, 1'b1);
            if (i == 0) check("program bit", sw[SR_PROG_ERR], 1'b0);
            eng_pulse('{1'b1, 1'b0, 1'b0});
            step(1'b1, CMD_STATUS_CLEAR);
            st(8'h80, 8'hB6);
        end
        for (int i = 0; i < 2; i++) begin
            step(1'b1, CMD_WRITE_BUFFER);
            eng_pulse('{1'b0, 1'b0, 1'b1});
            st(8'h98, 8'hBE);
            rd(CMD_STATUS_READ, 16'h0098, 16'h00BE, 1'b0);
            step(1'b1, CMD_RESET);
            st(8'h98, 8'hBE);
            step(1'b1, i ? CMD_STATUS_CLEAR : CMD_BUF_ABORT_RESET);
            st(8'h80, 8'hBE);
        end
        step(1'b1, CMD_ECC_ENTRY);
        check("overlay", ecc_overlay, 1'b1);
        u = 3'($random(seed));
        rd(CMD_ECC_READ, {13'h0, u}, 16'h001F, 1'b0, u);
        int_enable = 1'b1;
        step(1'b0, CMD_OTHER, 1'b0, 3'h0, 2'b01);
        check("irq", int_n, 1'b0);
        @(negedge clk);
        check("irq end", int_n, 1'b1);
        u = 3'($random(seed));
        rd(CMD_ECC_READ, {12'h0, 1'b1, u}, 16'h001F, 1'b0, u);
        a = ADDR_W'($random(seed));
        step(1'b0, CMD_OTHER, 1'b0, 3'h0, 2'b10, a);
        check("irq", int_n, 1'b0);
        check("trap", trap_addr, a);
        step(1'b0, CMD_OTHER, 1'b0, 3'h0, 2'b10, ~a);
        check("trap", trap_addr, a);
        u = 3'($random(seed));
        rd(CMD_ECC_READ, {15'h0008, u[0]}, 16'h0011, 1'b0, u);
        step(1'b1, CMD_ASO_EXIT);
        check("overlay", ecc_overlay, 1'b0);
        check("trap", trap_addr, 0);
        step(1'b1, CMD_ECC_ENTRY);
        rd(CMD_ECC_READ, {12'h0, 1'b1, u}, 16'h001F, 1'b0, u, 2'b01);
        step(1'b1, CMD_ASO_EXIT);
        step(1'b1, CMD_ECC_ENTRY);
        rd(CMD_ECC_READ, {13'h0, u}, 16'h001F, 1'b0, u);
        step(1'b1, CMD_ASO_EXIT);
        step(1'b1, CMD_ECC_ENTRY);
        step(1'b0, CMD_OTHER, 1'b0, 3'h0, 2'b10, a);
        check("trap", trap_addr, a);
        rstn = 1'b0;
        repeat (2) @(negedge clk);
        rstn = 1'b1;
        check("trap", trap_addr, 0);
        check("overlay", ecc_overlay, 1'b0);
        st(8'h80, 8'hFF);
        step(1'b1, CMD_ECC_ENTRY);
        rd(CMD_ECC_READ, {13'h0, u}, 16'h001F, 1'b0, u);
        step(1'b1, CMD_ASO_EXIT);
        int_enable = 1'b0;
        for (int i = 0; i < 3; i++) begin
            stall_enable = (i == 1);
            frame_go = 1'b1;
            repeat (60) @(negedge clk);
            step(1'b0, CMD_OTHER, 1'b0, 3'h0, {i == 1, 1'b0}, a);
            check("irq off", int_n, 1'b1);
            for (int k = 0; k < 3000 && frame_done !== 1'b1; k++)
                @(negedge clk);
            frame_go = 1'b0;
            check("bus error", bus_error, i == 1);
            check("strobe moved", toggles > 8, 1'b1);
            @(negedge clk);
        end
        check("reads pending", expq.size(), 0);
        summarize();
    end
endmodule // flash_error_status_reporting_test
